// [verilog/pin_key_mode_regs.sv]
// pin 0 function select, address change key, soft reset and mode registers
`timescale 1ns/1ps
// Notes on behaviour
// [R01] select 0x0 drives pin 0 with the legacy interrupt behaviour
// [R02] select 0x1 puts the configured interrupt signal on pin 0
// [R03] select 0x2 rises at first slot start, falls at last slot end
// [R04] selects 0x5, 0x6, 0x7 copy slot A, slot B or both LED pulses
// [R05] selects 0xC, 0xD, 0xE flag data cycles of slot A, B or either
// [R06] select 0xF toggles pin 0 every sample, half the sample rate
// [R07] select 0x10 holds pin 0 low, 0x11 holds it high
// [R08] select 0x13 routes the 32 kHz oscillator clock onto pin 0
// [R09] host writes only listed select codes; others are unsupported
// [R10] address change writes need key authorisation; key resets locked
// [R11] key 0x04AD unlocks address change whatever the pin levels
// [R12] keys 0x44AD, 0x84AD, 0xC4AD need pin 0, pin 1, both pins high
// [R13] writing 1 to reset bit resets device; bit clears when done
// [R14] reset write is accepted, then standby with all defaults; soft reset does not clear slot_span, half_rate or the read data
// [R15] two-bit mode field selects operating state; 0x0 is standby
// [R16] any other key value keeps address changes locked
module pin_key_mode_regs (
   input wire logic CLOCK, // core clock, 125 MHz
   input wire logic RST, // synchronous reset, active high
   input wire logic [7:0] REG_ADDR, // register index from serial port
   input wire logic [15:0] REG_WDATA, // write data
   input wire logic REG_WR, // write strobe, one cycle
   output logic [15:0] REG_RDATA, // read data for REG_ADDR, registered
   input wire logic ADDR_WR_REQ, // attempt to change the slave address
   output logic ADDR_WR_OK, // address change write accepted, pulse
   output logic ADDR_UNLOCKED, // key currently authorises change
   input wire logic PIN0_LEVEL, // sensed level of pin 0
   input wire logic PIN1_LEVEL, // sensed level of pin 1
   input wire logic LEGACY_INT, // legacy style interrupt level
   input wire logic CFG_INT, // configured interrupt level
   input wire logic FIRST_SLOT_START, // pulse, first slot begins
   input wire logic LAST_SLOT_END, // pulse, last slot ends
   input wire logic LED_PULSE_A, // slot A LED pulse level
   input wire logic LED_PULSE_B, // slot B LED pulse level
   input wire logic DATA_CYCLE_A, // slot A data cycle pulse
   input wire logic DATA_CYCLE_B, // slot B data cycle pulse
   input wire logic SAMPLE_TICK, // pulse once per sample
   input wire logic OSC_32K, // low frequency oscillator clock
   output logic PIN0_OUT, // pin 0 drive value, registered
   output logic PIN0_OE, // pin 0 output enable, high while driving
   output logic SOFT_RESET, // device wide reset pulse
   output logic [1:0] MODE // operating mode, 0 is standby
);
   import pin_key_mode_pkg::*;

   typedef enum logic [0:0] {RUN, RESETTING} reset_state_e;

   ////////////////////////////////////////////////////////////////////////
   // register file
   // reserved bits are not stored; the host is told to write them zero
   logic [4:0] pin_select;
   logic [15:0] addr_key;
   logic [1:0] mode;
   reset_state_e reset_state;
   logic [4:0] next_pin_select;
   logic [15:0] next_addr_key;
   logic [1:0] next_mode;
   reset_state_e next_reset_state;

   // writes, and the soft reset sequence that restores the select, key and mode defaults
   always_comb begin
      next_pin_select = pin_select;
      next_addr_key = addr_key;
      next_mode = mode;
      next_reset_state = RUN;
      unique case (reset_state)
         RESETTING: begin
            // writes during the reset cycle are dropped on purpose
            next_pin_select = SELECT_RESET; // [R14]
            next_addr_key = KEY_RESET; // [R14]
            next_mode = MODE_STANDBY; // [R14] [R15]
            next_reset_state = RUN; // [R13]
         end
         RUN: begin
            if (REG_WR) begin
               unique case (REG_ADDR)
                  OFS_PIN_SELECT: begin
                     next_pin_select = REG_WDATA[SEL_MSB:SEL_LSB]; // [R09]
                  end
                  OFS_ADDR_KEY: begin
                     next_addr_key = REG_WDATA; // [R10]
                  end
                  OFS_SOFT_RESET: begin
                     if (REG_WDATA[RESET_BIT]) begin
                        next_reset_state = RESETTING; // [R13]
                     end
                  end
                  OFS_MODE: begin
                     next_mode = REG_WDATA[MODE_MSB:MODE_LSB]; // [R15]
                  end
                  default: begin
                  end
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         pin_select <= SELECT_RESET;
         addr_key <= KEY_RESET; // [R10]
         mode <= MODE_RESET;
         reset_state <= RUN;
      end else begin
         pin_select <= next_pin_select;
         addr_key <= next_addr_key;
         mode <= next_mode;
         reset_state <= next_reset_state;
      end
   end

   // the reset bit reads back 1 only in the single resetting cycle,
   // so a host that polls it always finds it cleared once done
   assign SOFT_RESET = (reset_state == RESETTING); // [R13]
   assign MODE = mode; // [R15]

   ////////////////////////////////////////////////////////////////////////
   // address change key check
   logic unlocked;

   // unknown key values fall to locked, same as the reset value
   always_comb begin
      unique case (addr_key)
         KEY_ALWAYS: unlocked = 1'b1; // [R11]
         KEY_PIN0: unlocked = PIN0_LEVEL; // [R12]
         KEY_PIN1: unlocked = PIN1_LEVEL; // [R12]
         KEY_BOTH: unlocked = PIN0_LEVEL & PIN1_LEVEL; // [R12]
         default: unlocked = 1'b0; // [R16]
      endcase
   end

   // pin levels are live: a pin-gated key can lock again at any time,
   // so the host must hold the pin while it writes the new address
   assign ADDR_UNLOCKED = unlocked;
   // no change is accepted while the soft reset is in flight
   assign ADDR_WR_OK = ADDR_WR_REQ & unlocked & (reset_state == RUN); // [R10]

   ////////////////////////////////////////////////////////////////////////
   // read back
   logic [15:0] rdata;
   logic [15:0] next_rdata;

   // reserved bits and unmapped indices read zero
   always_comb begin
      next_rdata = 16'h0000;
      unique case (REG_ADDR)
         OFS_PIN_SELECT: next_rdata[SEL_MSB:SEL_LSB] = pin_select;
         OFS_ADDR_KEY: next_rdata = addr_key;
         OFS_SOFT_RESET: next_rdata[RESET_BIT] = SOFT_RESET; // [R13]
         OFS_MODE: next_rdata[MODE_MSB:MODE_LSB] = mode;
         default: next_rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         rdata <= 16'h0000;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign REG_RDATA = rdata;

   ////////////////////////////////////////////////////////////////////////
   // pin 0 function mux
   logic pin0;
   logic slot_span;
   logic half_rate;
   logic next_pin0;
   logic next_slot_span;
   logic next_half_rate;

   // span and toggle state track always so a select change is glitch free
   always_comb begin
      next_slot_span = slot_span;
      if (FIRST_SLOT_START) begin
         next_slot_span = 1'b1; // [R03]
      end else if (LAST_SLOT_END) begin
         next_slot_span = 1'b0; // [R03]
      end
      next_half_rate = half_rate ^ SAMPLE_TICK; // [R06]
      unique case (pin_select)
         FN_LEGACY_INT: next_pin0 = LEGACY_INT; // [R01]
         FN_INT: next_pin0 = CFG_INT; // [R02]
         FN_SLOT_SPAN: next_pin0 = next_slot_span; // [R03]
         FN_PULSE_A: next_pin0 = LED_PULSE_A; // [R04]
         FN_PULSE_B: next_pin0 = LED_PULSE_B; // [R04]
         FN_PULSE_AB: next_pin0 = LED_PULSE_A | LED_PULSE_B; // [R04]
         FN_DATA_A: next_pin0 = DATA_CYCLE_A; // [R05]
         FN_DATA_B: next_pin0 = DATA_CYCLE_B; // [R05]
         FN_DATA_AB: next_pin0 = DATA_CYCLE_A | DATA_CYCLE_B; // [R05]
         FN_HALF_RATE: next_pin0 = next_half_rate; // [R06]
         FN_LOW: next_pin0 = 1'b0; // [R07]
         FN_HIGH: next_pin0 = 1'b1; // [R07]
         FN_OSC: next_pin0 = OSC_32K; // [R08]
         // unsupported codes: hold low rather than float
         default: next_pin0 = 1'b0; // [R09]
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         pin0 <= 1'b0;
         slot_span <= 1'b0;
         half_rate <= 1'b0;
      end else begin
         pin0 <= next_pin0;
         slot_span <= next_slot_span;
         half_rate <= next_half_rate;
      end
   end

   // every function lags its source by one clock; the registered pin
   // costs that cycle but keeps mux glitches off the pad
   assign PIN0_OUT = pin0;
   // pin 0 is always an output in every supported function
   assign PIN0_OE = 1'b1;
endmodule

// [verilog/pin_key_mode_pkg.sv]
// constants for the pin select, address key, reset and mode registers
package pin_key_mode_pkg;
   // register offsets (register index on the internal access port)
   localparam logic [7:0] OFS_PIN_SELECT = 8'h0b;
   localparam logic [7:0] OFS_ADDR_KEY = 8'h0d;
   localparam logic [7:0] OFS_SOFT_RESET = 8'h0f;
   localparam logic [7:0] OFS_MODE = 8'h10;
   // field positions
   localparam int SEL_LSB = 0;
   localparam int SEL_MSB = 4;
   localparam int RESET_BIT = 0;
   localparam int MODE_LSB = 0;
   localparam int MODE_MSB = 1;
   // values after reset
   localparam logic [4:0] SELECT_RESET = 5'h00;
   localparam logic [15:0] KEY_RESET = 16'h0000;
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam logic [1:0] MODE_STANDBY = 2'h0;
   // address change unlock codes
   localparam logic [15:0] KEY_ALWAYS = 16'h04ad;
   localparam logic [15:0] KEY_PIN0 = 16'h44ad;
   localparam logic [15:0] KEY_PIN1 = 16'h84ad;
   localparam logic [15:0] KEY_BOTH = 16'hc4ad;
   // pin 0 function codes
   localparam logic [4:0] FN_LEGACY_INT = 5'h00;
   localparam logic [4:0] FN_INT = 5'h01;
   localparam logic [4:0] FN_SLOT_SPAN = 5'h02;
   localparam logic [4:0] FN_PULSE_A = 5'h05;
   localparam logic [4:0] FN_PULSE_B = 5'h06;
   localparam logic [4:0] FN_PULSE_AB = 5'h07;
   localparam logic [4:0] FN_DATA_A = 5'h0c;
   localparam logic [4:0] FN_DATA_B = 5'h0d;
   localparam logic [4:0] FN_DATA_AB = 5'h0e;
   localparam logic [4:0] FN_HALF_RATE = 5'h0f;
   localparam logic [4:0] FN_LOW = 5'h10;
   localparam logic [4:0] FN_HIGH = 5'h11;
   localparam logic [4:0] FN_OSC = 5'h13;
endpackage

// [testbench/pin_key_mode_chk.sv]
// port assertions for the pin, key, reset and mode registers
`timescale 1ns/1ps
module pin_key_mode_chk
   import pin_key_mode_pkg::*;
(
   input wire logic CLOCK, // clock
   input wire logic RST, // reset
   input wire logic [7:0] REG_ADDR, // index
   input wire logic [15:0] REG_WDATA, // data in
   input wire logic REG_WR, // strobe
   input wire logic [15:0] REG_RDATA, // data out
   input wire logic ADDR_WR_REQ, // change try
   input wire logic ADDR_WR_OK, // change taken
   input wire logic ADDR_UNLOCKED, // key open
   input wire logic PIN0_OE, // enable
   input wire logic SOFT_RESET, // reset pulse
   input wire logic [1:0] MODE // mode
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   // a soft reset cycle must refuse the change even with the key open
   addr_ok_a: assert property (ADDR_WR_OK == (ADDR_WR_REQ && ADDR_UNLOCKED
      && !SOFT_RESET)) else $error("address change acceptance wrong");
   reset_pulse_a: assert property (SOFT_RESET |=> !SOFT_RESET)
      else $error("soft reset longer than one cycle");
   reset_cause_a: assert property ($rose(SOFT_RESET) |-> $past(REG_WR &&
      REG_ADDR == OFS_SOFT_RESET && REG_WDATA[0]))
      else $error("soft reset without a reset write");
   mode_write_a: assert property (REG_WR && REG_ADDR == OFS_MODE &&
      !SOFT_RESET |=> MODE == $past(REG_WDATA[1:0]))
      else $error("mode write not taken");
   reset_defaults_a: assert property (SOFT_RESET |=> MODE == MODE_STANDBY
      && !ADDR_UNLOCKED) else $error("soft reset left state");
   mode_reserved_a: assert property ($past(REG_ADDR) == OFS_MODE |->
      REG_RDATA[15:2] == 14'h0000) else $error("mode reserved set");
   reset_reserved_a: assert property ($past(REG_ADDR) == OFS_SOFT_RESET |->
      REG_RDATA[15:1] == 15'h0000) else $error("reset reserved set");
   pin_drive_a: assert property (PIN0_OE)
      else $error("pin 0 not driven");
endmodule
bind pin_key_mode_regs pin_key_mode_chk pin_key_mode_chk_inst (
   .CLOCK(CLOCK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
   .REG_WR(REG_WR), .REG_RDATA(REG_RDATA), .ADDR_WR_REQ(ADDR_WR_REQ),
   .ADDR_WR_OK(ADDR_WR_OK), .ADDR_UNLOCKED(ADDR_UNLOCKED),
   .PIN0_OE(PIN0_OE), .SOFT_RESET(SOFT_RESET), .MODE(MODE));

// [testbench/timing_src.sv]
// timing core stand-in: sample ticks and a scaled slow oscillator
`timescale 1ns/1ps
module timing_src (
   input wire logic CLOCK, // core clock
   output logic SAMPLE_TICK = 1'b0, // one cycle per sample
   output logic OSC_32K = 1'b0 // slow clock, scaled down for run time
);
   logic [3:0] cnt = 4'h0;
   // driven at the falling edge, away from the design's sampling edge
   always @(negedge CLOCK) begin
      cnt <= cnt + 4'h1;
      SAMPLE_TICK <= (cnt % 5 == 0);
      OSC_32K <= cnt[3];
   end
endmodule

// [testbench/testbench.sv]
// self-checking bench for the pin, key, reset and mode registers
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
   $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module testbench;
   import pin_key_mode_pkg::*;
   logic clock = 1'b0, rst = 1'b1, wr = 1'b0, req = 1'b1;
   logic [7:0] addr = 8'h00, src = 8'h00;
   logic [15:0] wdata = 16'h0000, rdata;
   logic [1:0] pins = 2'h0, mode;
   logic ok, unl, pout, poe, sres, tick, osc, p, t;
   int mismatches = 0, num_checks = 0;
   logic [4:0] code [12] = '{FN_LEGACY_INT, FN_INT, FN_SLOT_SPAN,
      FN_SLOT_SPAN, FN_PULSE_A, FN_PULSE_B, FN_PULSE_AB, FN_DATA_A,
      FN_DATA_B, FN_DATA_AB, FN_LOW, FN_HIGH};
   logic [7:0] mask [12] = '{1, 2, 4, 8, 16, 32, 32, 64, 128, 64, 255, 0};
   logic [1:0] hilo [12] = '{2, 2, 3, 0, 2, 2, 2, 2, 2, 2, 0, 3};
   logic [15:0] key [9] = '{KEY_ALWAYS, KEY_PIN0, KEY_PIN0, KEY_PIN1,
      KEY_PIN1, KEY_BOTH, KEY_BOTH, 16'h04ac, KEY_RESET};
   logic [1:0] kp [9] = '{0, 1, 2, 2, 1, 1, 3, 3, 3};
   logic [8:0] kx = 9'b001001011;
   always #4 clock = ~clock;
   pin_key_mode_regs pin_key_mode_regs_inst (.CLOCK(clock), .RST(rst),
      .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RDATA(rdata),
      .ADDR_WR_REQ(req), .ADDR_WR_OK(ok), .ADDR_UNLOCKED(unl),
      .PIN0_LEVEL(pins[0]), .PIN1_LEVEL(pins[1]), .LEGACY_INT(src[0]),
      .CFG_INT(src[1]), .FIRST_SLOT_START(src[2]), .LAST_SLOT_END(src[3]),
      .LED_PULSE_A(src[4]), .LED_PULSE_B(src[5]), .DATA_CYCLE_A(src[6]),
      .DATA_CYCLE_B(src[7]), .SAMPLE_TICK(tick), .OSC_32K(osc),
      .PIN0_OUT(pout), .PIN0_OE(poe), .SOFT_RESET(sres), .MODE(mode));
   timing_src timing_src_inst (.CLOCK(clock), .SAMPLE_TICK(tick),
      .OSC_32K(osc));
   ////////////////////////////////////////////////////////////////////
   // one-cycle write strobe, launched and dropped at falling edges
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(negedge clock);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clock);
      wr = 1'b0;
   endtask
   // read data lags the index by one edge
   task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
      @(negedge clock);
      addr = a;
      @(negedge clock);
      `CHK(rdata, e)
   endtask
   task automatic chk_defaults;
      rd_reg(OFS_PIN_SELECT, 16'h0000);
      rd_reg(OFS_ADDR_KEY, KEY_RESET);
      rd_reg(OFS_SOFT_RESET, 16'h0000);
      rd_reg(OFS_MODE, 16'h0000);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // the whole run is well under a thousand cycles
   initial begin
      #100000;
      mismatches++;
      results();
   end
   initial begin
      repeat (10) @(negedge clock);
      rst = 1'b0;
      chk_defaults();
      `CHK(poe, 1'b1)
      wr_reg(OFS_MODE, 16'hfff2);
      rd_reg(OFS_MODE, 16'h0002);
      wr_reg(8'h20, 16'hffff);
      rd_reg(OFS_MODE, 16'h0002);
      $display("test registers done");
      for (int i = 0; i < 12; i++) begin
         wr_reg(OFS_PIN_SELECT, {11'h000, code[i]});
         src = mask[i];
         @(negedge clock);
         `CHK(pout, hilo[i][1])
         src = 8'h00;
         @(negedge clock);
         `CHK(pout, hilo[i][0])
      end
      wr_reg(OFS_PIN_SELECT, {11'h000, FN_HALF_RATE});
      repeat (12) begin
         @(negedge clock);
         p = pout;
         @(posedge clock);
         t = tick;
         @(negedge clock);
         `CHK(pout, p ^ t)
      end
      wr_reg(OFS_PIN_SELECT, {11'h000, FN_OSC});
      repeat (20) begin
         @(posedge clock);
         t = osc;
         @(negedge clock);
         `CHK(pout, t)
      end
      $display("test pin functions done");
      for (int i = 0; i < 9; i++) begin
         wr_reg(OFS_ADDR_KEY, key[i]);
         pins = kp[i];
         #1 `CHK({unl, ok}, {2{kx[i]}})
      end
      $display("test address key done");
      wr_reg(OFS_SOFT_RESET, 16'h0000);
      `CHK(sres, 1'b0)
      wr_reg(OFS_ADDR_KEY, KEY_ALWAYS);
      wr_reg(OFS_MODE, 16'h0002);
      // no request, no acceptance, even with the key open
      req = 1'b0;
      #1 `CHK({unl, ok}, 2'b10)
      // strobe held up: reset write, then a write in the reset cycle
      @(negedge clock);
      req = 1'b1;
      addr = OFS_SOFT_RESET;
      wdata = 16'h0001;
      wr = 1'b1;
      @(negedge clock);
      `CHK({sres, ok}, 2'b10)
      addr = OFS_MODE;
      wdata = 16'h0001;
      @(negedge clock);
      wr = 1'b0;
      `CHK({sres, mode, unl}, 4'h0)
      chk_defaults();
      $display("test soft reset done");
      results();
   end
endmodule
